// ---- src/gain_amp_control.sv ----
// register file and analog switch control of the programmable gain amplifier
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
`include "gain_amp_defs.svh"

// How it works
// - gain code 0..3 selects 10x,20x,40x,80x; other codes flagged reserved
// - gain and offset trim registers read and write at any time
// - trim fields map 011..001 to -3..-1, 111..101 to +1..+3, 000/100 zero
// - factory test register always readable, writable only in special mode
// - enable clear: low power, inputs open, outputs undriven
// - reference select honoured only while enabled; 01 selects none
// - offset calibration switch closed only while its bit is set
module gain_amp_control (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [7:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    input wire logic special_mode,
    output logic amp_enable,
    output logic amp_output_drive,
    output logic offset_cal_connect,
    output logic [3:0] gain_code,
    output logic [6:0] gain_factor,
    output logic gain_reserved,
    output logic signed [2:0] coarse_steps,
    output logic signed [2:0] fine_steps,
    output logic ref_mid_supply_on,
    output logic reference_pin_zero_on,
    output logic reference_pin_one_on,
    output logic [2:0] factory_bits
);
    import gain_amp_pkg::*;

    function automatic trim_steps_t trim_map(input logic [2:0] c);
        unique case (c)
            3'h3: trim_map = -3'sh3;
            3'h2: trim_map = -3'sh2;
            3'h1: trim_map = -3'sh1;
            3'h7: trim_map = 3'sh1;
            3'h6: trim_map = 3'sh2;
            3'h5: trim_map = 3'sh3;
            default: trim_map = 3'sh0;
        endcase
    endfunction

    function automatic gain_factor_t gain_map(input logic [3:0] g);
        unique case (g)
            4'h0: gain_map = 7'h0a;
            4'h1: gain_map = 7'h14;
            4'h2: gain_map = 7'h28;
            4'h3: gain_map = 7'h50;
            default: gain_map = 7'h00;
        endcase
    endfunction

    logic enable_r, enable_nxt;
    logic cal_r, cal_nxt;
    ref_sel_t refsel_r, refsel_nxt;
    logic [3:0] gain_r, gain_nxt;
    logic [5:0] offset_r, offset_nxt;
    logic [2:0] factory_r, factory_nxt;
    logic [7:0] rdata_nxt;
    logic spec_meta_r, spec_r;

    // special mode arrives from chip level, treated as asynchronous
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            spec_meta_r <= 1'b0;
            spec_r <= 1'b0;
        end else begin
            spec_meta_r <= special_mode;
            spec_r <= spec_meta_r;
        end
    end

    always_comb begin
        enable_nxt = enable_r;
        cal_nxt = cal_r;
        refsel_nxt = refsel_r;
        gain_nxt = gain_r;
        offset_nxt = offset_r;
        factory_nxt = factory_r;
        rdata_nxt = 8'h00;
        // unmapped offsets and the reserved hole write nothing and read back zero
        if (bus_wr) begin
            unique case (bus_addr)
                `ADDR_ENABLE: begin
                    enable_nxt = bus_wdata[`BIT_AMP_ENABLE];
                    cal_nxt = bus_wdata[`BIT_OFFSET_CAL];
                end
                `ADDR_CONTROL: refsel_nxt = ref_sel_t'(bus_wdata[`REFSEL_LSB +: 2]);
                `ADDR_GAIN: gain_nxt = bus_wdata[3:0];
                `ADDR_OFFSET: offset_nxt = bus_wdata[5:0];
                `ADDR_FACTORY: begin
                    // test-only bits: outside special mode a write is dropped silently
                    if (spec_r) begin
                        factory_nxt = bus_wdata[2:0];
                    end
                end
                default: ;
            endcase
        end
        if (bus_rd) begin
            unique case (bus_addr)
                `ADDR_ENABLE: rdata_nxt = {6'h00, cal_r, enable_r};
                `ADDR_CONTROL: rdata_nxt = {2'h0, refsel_r, 4'h0};
                `ADDR_GAIN: rdata_nxt = {4'h0, gain_r};
                `ADDR_OFFSET: rdata_nxt = {2'h0, offset_r};
                `ADDR_FACTORY: rdata_nxt = {5'h00, factory_r};
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            enable_r <= 1'b0;
            cal_r <= 1'b0;
            refsel_r <= REF_MID_SUPPLY;
            gain_r <= `GAIN_RESET;
            offset_r <= `OFFSET_RESET;
            factory_r <= `FACTORY_RESET;
            bus_rdata <= 8'h00;
        end else begin
            enable_r <= enable_nxt;
            cal_r <= cal_nxt;
            refsel_r <= refsel_nxt;
            gain_r <= gain_nxt;
            offset_r <= offset_nxt;
            factory_r <= factory_nxt;
            bus_rdata <= rdata_nxt;
        end
    end

    // analog controls are registered from the next register values so they
    // follow a write on the same edge, keeping all outputs flop-driven
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            amp_enable <= 1'b0;
            amp_output_drive <= 1'b0;
            offset_cal_connect <= 1'b0;
            gain_code <= `GAIN_RESET;
            gain_factor <= 7'h00;
            gain_reserved <= 1'b0;
            coarse_steps <= 3'sh0;
            fine_steps <= 3'sh0;
            ref_mid_supply_on <= 1'b0;
            reference_pin_zero_on <= 1'b0;
            reference_pin_one_on <= 1'b0;
            factory_bits <= `FACTORY_RESET;
        end else begin
            amp_enable <= enable_nxt;
            amp_output_drive <= enable_nxt;
            offset_cal_connect <= enable_nxt & cal_nxt;
            gain_code <= gain_nxt;
            gain_factor <= gain_map(gain_nxt);
            gain_reserved <= (gain_nxt > 4'h3);
            coarse_steps <= trim_map(offset_nxt[5:3]);
            fine_steps <= trim_map(offset_nxt[2:0]);
            ref_mid_supply_on <= enable_nxt & (refsel_nxt == REF_MID_SUPPLY);
            reference_pin_zero_on <= enable_nxt & (refsel_nxt == REF_PIN_ZERO);
            reference_pin_one_on <= enable_nxt & (refsel_nxt == REF_PIN_ONE);
            factory_bits <= factory_nxt;
        end
    end

    // control outputs change on the edge that takes a write and are sampled at the next edge, so the write checks use |=>
    a_gain_factor: assert property (@(posedge clk_sys) disable iff (sys_rst)
        bus_wr && bus_addr == `ADDR_GAIN && bus_wdata[3:0] == 4'h3 |=> gain_factor == 7'h50)
        else $error("gain code 3 not 80x");
    a_gain_reserved: assert property (@(posedge clk_sys) disable iff (sys_rst)
        bus_wr && bus_addr == `ADDR_GAIN && bus_wdata[3:0] > 4'h3 |=> gain_reserved
        && gain_factor == 7'h00)
        else $error("reserved gain code not flagged");
    // a gain write followed on the very next cycle by a read of the same register
    sequence s_gain_write;
        bus_wr && bus_addr == `ADDR_GAIN;
    endsequence
    sequence s_gain_read;
        bus_rd && !bus_wr && bus_addr == `ADDR_GAIN;
    endsequence
    a_gain_readback: assert property (@(posedge clk_sys) disable iff (sys_rst)
        s_gain_write ##1 s_gain_read |=> bus_rdata == {4'h0, $past(bus_wdata[3:0], 2)})
        else $error("gain readback mismatch");
    a_rdata_idle: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !bus_rd |=> bus_rdata == 8'h00)
        else $error("read data not cleared without a read");
    a_trim_coarse: assert property (@(posedge clk_sys) disable iff (sys_rst)
        bus_wr && bus_addr == `ADDR_OFFSET && bus_wdata[5:3] == 3'h5 |=> coarse_steps == 3'sh3)
        else $error("coarse 101 not +3");
    a_trim_fine: assert property (@(posedge clk_sys) disable iff (sys_rst)
        bus_wr && bus_addr == `ADDR_OFFSET && bus_wdata[2:0] == 3'h3 |=> fine_steps == -3'sh3)
        else $error("fine 011 not -3");
    a_factory_lock: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !spec_r |=> factory_r == $past(factory_r))
        else $error("factory register written outside special mode");
    a_factory_special: assert property (@(posedge clk_sys) disable iff (sys_rst)
        spec_r && bus_wr && bus_addr == `ADDR_FACTORY
        |=> factory_bits == $past(bus_wdata[2:0]))
        else $error("factory register write lost in special mode");
    a_disabled_quiet: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !amp_enable |-> !amp_output_drive && !offset_cal_connect
        && !ref_mid_supply_on && !reference_pin_zero_on && !reference_pin_one_on)
        else $error("disabled amplifier still connected");
    a_ref_reserved: assert property (@(posedge clk_sys) disable iff (sys_rst)
        refsel_r == REF_RESERVED |-> !(ref_mid_supply_on || reference_pin_zero_on
        || reference_pin_one_on))
        else $error("reserved reference select drove a source");
    a_ref_pin_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
        amp_enable && refsel_r == REF_PIN_ZERO |-> reference_pin_zero_on
        && !ref_mid_supply_on && !reference_pin_one_on)
        else $error("reference pin zero not selected alone");
    a_ref_pin_one: assert property (@(posedge clk_sys) disable iff (sys_rst)
        amp_enable && refsel_r == REF_PIN_ONE |-> reference_pin_one_on
        && !ref_mid_supply_on && !reference_pin_zero_on)
        else $error("reference pin one not selected alone");
    a_cal_switch: assert property (@(posedge clk_sys) disable iff (sys_rst)
        bus_wr && bus_addr == `ADDR_ENABLE |=> offset_cal_connect
        == ($past(bus_wdata[`BIT_OFFSET_CAL]) && $past(bus_wdata[`BIT_AMP_ENABLE])))
        else $error("calibration switch wrong");
endmodule // gain_amp_control

// ---- src/gain_amp_defs.svh ----
// register offsets, field positions and reset values of the gain amplifier control
`ifndef GAIN_AMP_DEFS_SVH
`define GAIN_AMP_DEFS_SVH
`define ADDR_ENABLE 8'h00
`define ADDR_CONTROL 8'h01
`define ADDR_GAIN 8'h02
`define ADDR_OFFSET 8'h03
`define ADDR_RSVD_LO 8'h04
`define ADDR_RSVD_HI 8'h06
`define ADDR_FACTORY 8'h07
`define BIT_AMP_ENABLE 0
`define BIT_OFFSET_CAL 1
`define REFSEL_LSB 4
`define GAIN_RESET 4'h0
`define OFFSET_RESET 6'h00
`define FACTORY_RESET 3'h0
`define REFSEL_RESET 2'h0
`endif

// ---- src/gain_amp_pkg.sv ----
// types of the gain amplifier control
package gain_amp_pkg;
    typedef enum logic [1:0] {
        REF_MID_SUPPLY,
        REF_RESERVED,
        REF_PIN_ZERO,
        REF_PIN_ONE
    } ref_sel_t;
    typedef logic signed [2:0] trim_steps_t;
    typedef logic [6:0] gain_factor_t;
endpackage

// ---- tb/test_gain_amp_control.sv ----
// self-checking testbench of the gain amplifier control register block
`timescale 1ns/10ps
module test_gain_amp_control;
    logic clk_sys, sys_rst, bus_wr, bus_rd, special_mode;
    logic [7:0] bus_addr, bus_wdata, bus_rdata;
    logic amp_enable, amp_output_drive, offset_cal_connect, gain_reserved;
    logic ref_mid_supply_on, reference_pin_zero_on, reference_pin_one_on;
    logic [3:0] gain_code;
    logic [6:0] gain_factor;
    logic signed [2:0] coarse_steps, fine_steps;
    logic [2:0] factory_bits;
    logic [31:0] seed;
    int failures, checked;
    // stand-in for the amplifier settling time, in bus clock cycles; value arbitrary
    localparam int SETTLE_CYCLES = 4;

    gain_amp_control u_gain_amp_control (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .special_mode(special_mode), .amp_enable(amp_enable),
        .amp_output_drive(amp_output_drive), .offset_cal_connect(offset_cal_connect),
        .gain_code(gain_code), .gain_factor(gain_factor), .gain_reserved(gain_reserved),
        .coarse_steps(coarse_steps), .fine_steps(fine_steps),
        .ref_mid_supply_on(ref_mid_supply_on), .reference_pin_zero_on(reference_pin_zero_on),
        .reference_pin_one_on(reference_pin_one_on), .factory_bits(factory_bits));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction

    function automatic logic [6:0] gain_exp(input logic [3:0] c);
        case (c)
            4'h0: return 7'h0a;
            4'h1: return 7'h14;
            4'h2: return 7'h28;
            4'h3: return 7'h50;
            default: return 7'h00;
        endcase
    endfunction

    // two's complement step count of one trim field
    function automatic logic [2:0] trim_exp(input logic [2:0] c);
        case (c)
            3'h3: return 3'h5;
            3'h2: return 3'h6;
            3'h1: return 3'h7;
            3'h7: return 3'h1;
            3'h6: return 3'h2;
            3'h5: return 3'h3;
            default: return 3'h0;
        endcase
    endfunction

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // effects are looked at just after the edge that takes the write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
        #1;
    endtask

    // read data stand only in the cycle after the read edge
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        #1;
        chk(bus_rdata, exp);
    endtask

    // write and read back on the next cycle, no idle gap between the strobes
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
        @(posedge clk_sys);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
        bus_rd <= 1'b1;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        #1;
        chk(bus_rdata, exp);
    endtask

    // software holds each setting one settling time before it measures
    task automatic settle();
        repeat (SETTLE_CYCLES) @(posedge clk_sys);
        #1;
    endtask

    // calibration sweep order: -3 steps up to +3 steps
    function automatic logic [2:0] sweep_code(input int k);
        return (k < 4) ? 3'(3 - k) : 3'(11 - k);
    endfunction

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        failures++;
        tally_and_finish();
    end

    initial begin
        logic [7:0] v;
        logic e;
        int off, err, best_err, best_cs;
        logic [2:0] best_c, best_f;
        {sys_rst, bus_wr, bus_rd, special_mode, bus_addr, bus_wdata} = {4'h8, 16'h0000};
        seed = 32'h0000_0704;
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        #1;
        chk({amp_enable, offset_cal_connect, ref_mid_supply_on, factory_bits}, 8'h00);
        rd(8'h02, 8'h00);
        rd(8'h03, 8'h00);
        rd(8'h07, 8'h00);
        for (int i = 0; i < 16; i++) begin
            v = rnd();
            wr(8'h02, {v[7:4], i[3:0]});
            chk({gain_reserved, gain_factor}, {i > 3, gain_exp(i[3:0])});
            chk({4'h0, gain_code}, {4'h0, i[3:0]});
            rd(8'h02, {4'h0, i[3:0]});
            wr_rd(8'h02, {v[3:0], i[3:0]}, {4'h0, i[3:0]});
        end
        $display("gain test done");
        for (int i = 0; i < 64; i++) begin
            v = rnd();
            wr(8'h03, {v[7:6], i[5:0]});
            chk({5'h00, coarse_steps}, {5'h00, trim_exp(i[5:3])});
            chk({5'h00, fine_steps}, {5'h00, trim_exp(i[2:0])});
            rd(8'h03, {2'h0, i[5:0]});
        end
        $display("trim test done");
        for (int i = 0; i < 16; i++) begin
            e = i[0];
            wr(8'h00, {6'h00, i[1:0]});
            wr(8'h01, {2'h0, i[3:2], 4'h0});
            chk({amp_enable, amp_output_drive}, {e, e});
            chk({7'h00, offset_cal_connect}, {7'h00, e & i[1]});
            chk({ref_mid_supply_on, reference_pin_zero_on, reference_pin_one_on},
                {e & (i[3:2] == 0), e & (i[3:2] == 2), e & (i[3:2] == 3)});
            rd(8'h00, {6'h00, i[1:0]});
            rd(8'h01, {2'h0, i[3:2], 4'h0});
        end
        $display("enable and reference test done");
        // offset calibration run as software would, against a modelled input offset
        off = int'(rnd() % 8'h1f) - 15;
        wr(8'h01, 8'h00);
        wr(8'h00, 8'h03);
        wr(8'h02, 8'h03);
        chk({5'h00, offset_cal_connect, ref_mid_supply_on, gain_factor == 7'h50}, 8'h07);
        best_err = 99;
        for (int k = 0; k < 7; k++) begin
            wr(8'h03, {2'h0, sweep_code(k), 3'h0});
            settle();
            chk({5'h00, coarse_steps}, {5'h00, 3'(k - 3)});
            err = off + 4 * (k - 3);
            err = (err < 0) ? -err : err;
            if (err < best_err) begin
                best_err = err;
                best_cs = k - 3;
                best_c = sweep_code(k);
            end
        end
        best_err = 99;
        for (int k = 0; k < 7; k++) begin
            wr(8'h03, {2'h0, best_c, sweep_code(k)});
            settle();
            chk({5'h00, fine_steps}, {5'h00, 3'(k - 3)});
            err = off + 4 * best_cs + k - 3;
            err = (err < 0) ? -err : err;
            if (err < best_err) begin
                best_err = err;
                best_f = sweep_code(k);
            end
        end
        wr(8'h03, {2'h0, best_c, best_f});
        settle();
        chk(8'(off + 4 * coarse_steps + fine_steps), 8'h00);
        rd(8'h03, {2'h0, best_c, best_f});
        $display("calibration test done");
        wr(8'h07, 8'hff);
        chk({5'h00, factory_bits}, 8'h00);
        // mode input crosses two sync flops before it counts
        special_mode <= 1'b1;
        repeat (3) @(posedge clk_sys);
        wr(8'h07, 8'h05);
        chk({5'h00, factory_bits}, 8'h05);
        rd(8'h07, 8'h05);
        special_mode <= 1'b0;
        repeat (3) @(posedge clk_sys);
        wr(8'h07, 8'h02);
        rd(8'h07, 8'h05);
        rd(8'h05, 8'h00);
        $display("factory register test done");
        tally_and_finish();
    end
endmodule // test_gain_amp_control
